/* src/main_clock_rtc_beeper.sv */
// Main clock controller with time base, clock-out and beeper
`timescale 1ns/10ps

module main_clock_rtc_beeper #(
  parameter int TB_CYC_0 = mcc_pkg::TB_CYC_0,
  parameter int TB_CYC_1 = mcc_pkg::TB_CYC_1,
  parameter int TB_CYC_2 = mcc_pkg::TB_CYC_2,
  parameter int TB_CYC_3 = mcc_pkg::TB_CYC_3,
  parameter int BEEP_HALF_1 = mcc_pkg::BEEP_HALF_1,
  parameter int BEEP_HALF_2 = mcc_pkg::BEEP_HALF_2,
  parameter int BEEP_HALF_3 = mcc_pkg::BEEP_HALF_3
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic irq_mask_i,
  input wire logic halt_exec_i,
  input wire logic wake_i,
  output logic cpu_clk_en_o,
  output logic clock_out_o,
  output logic clock_out_oe_o,
  output logic beep_o,
  output logic beep_oe_o,
  output logic time_base_irq_o,
  output logic active_halt_o,
  output logic halt_o
);
  localparam int TB_MAX = (1 << mcc_pkg::TB_W) - 1;
  localparam int BEEP_MAX = (1 << mcc_pkg::BEEP_W) - 1;

  if (TB_CYC_0 < 2 || TB_CYC_1 < 2 || TB_CYC_2 < 2 || TB_CYC_3 < 2 ||
      TB_CYC_0 > TB_MAX || TB_CYC_1 > TB_MAX || TB_CYC_2 > TB_MAX ||
      TB_CYC_3 > TB_MAX) begin : g_bad_tb
    $error("Time base periods must lie in 2 .. 2**TB_W-1");
  end
  if (BEEP_HALF_1 < 2 || BEEP_HALF_2 < 2 || BEEP_HALF_3 < 2 ||
      BEEP_HALF_1 > BEEP_MAX || BEEP_HALF_2 > BEEP_MAX ||
      BEEP_HALF_3 > BEEP_MAX) begin : g_bad_beep
    $error("Tone half periods must lie in 2 .. 2**BEEP_W-1");
  end

  // Register fields
  logic mco_q;
  logic [1:0] cp_q;
  logic sms_q;
  logic [1:0] tb_sel_q;
  logic oie_q;
  logic oif_q;
  logic [1:0] tone_q;

  mcc_pkg::power_state_e ps_q;
  mcc_pkg::power_state_e ps_d;

  // Bus state
  logic wr_pend_q;
  logic [1:0] wr_sel_q;
  logic [31:0] hrdata_q;
  logic hready_q;

  // Output flops
  logic cpu_en_q;
  logic clk_out_q;
  logic clk_out_oe_q;
  logic beep_q;
  logic beep_oe_q;
  logic irq_q;
  logic ahalt_q;
  logic halt_q;

  logic addr_ok;
  logic [1:0] addr_sel;
  logic rd_csr;
  logic frozen;
  logic we_csr;
  logic we_bcr;
  logic tb_tick;
  logic tb_tick_raw;
  logic beep_tick;
  logic cpu_tick;
  logic tb_run;
  logic beep_run;
  logic cpu_run;
  logic cpu_en_d;
  logic [7:0] csr_view;
  logic [7:0] bcr_view;
  logic [mcc_pkg::TB_W-1:0] tb_period;
  logic [mcc_pkg::BEEP_W-1:0] beep_period;
  logic [mcc_pkg::CPU_W-1:0] cpu_period;

  // Bit 0 selects the control/status register, bit 1 the beep register
  function automatic logic [1:0] reg_decode(input logic [31:0] addr);
    reg_decode = {addr == mcc_pkg::BCR_ADDR, addr == mcc_pkg::CSR_ADDR};
  endfunction : reg_decode

  function automatic logic [mcc_pkg::TB_W-1:0] tb_cycles(input logic [1:0] sel);
    unique case (sel)
      2'b00: tb_cycles = mcc_pkg::TB_W'(TB_CYC_0);
      2'b01: tb_cycles = mcc_pkg::TB_W'(TB_CYC_1);
      2'b10: tb_cycles = mcc_pkg::TB_W'(TB_CYC_2);
      2'b11: tb_cycles = mcc_pkg::TB_W'(TB_CYC_3);
    endcase
  endfunction : tb_cycles

  // ---- Bus slave: zero wait states, always OKAY
  assign addr_ok = hsel_i && htrans_i[1] && hready_i;
  assign addr_sel = reg_decode(haddr_i);
  assign rd_csr = addr_ok && !hwrite_i && addr_sel[0];
  assign frozen = (ps_q != mcc_pkg::PS_RUN);
  // Register writes are ignored outside run mode
  assign we_csr = wr_pend_q && wr_sel_q[0] && !frozen;
  assign we_bcr = wr_pend_q && wr_sel_q[1] && !frozen;

  // Read view forwards a write still in its data phase
  always_comb begin
    csr_view = {mco_q, cp_q, sms_q, tb_sel_q, oie_q, oif_q};
    bcr_view = {6'h00, tone_q};
    if (we_csr) begin
      csr_view[7:1] = hwdata_i[7:1];
    end
    if (we_bcr) begin
      bcr_view[1:0] = hwdata_i[mcc_pkg::TONE_LSB +: 2];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wr_pend_q <= 1'b0;
      wr_sel_q <= 2'b00;
    end else if (ce_i) begin
      wr_pend_q <= addr_ok && hwrite_i;
      wr_sel_q <= addr_sel;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      hrdata_q <= 32'h00000000;
      hready_q <= 1'b0;
    end else if (ce_i) begin
      hready_q <= 1'b1;
      if (addr_ok && !hwrite_i && addr_sel[0]) begin
        hrdata_q <= {24'h000000, csr_view};
      end else if (addr_ok && !hwrite_i && addr_sel[1]) begin
        hrdata_q <= {24'h000000, bcr_view};
      end else begin
        hrdata_q <= 32'h00000000;
      end
    end
  end

  // ---- Control fields; flag is read-only and ignores writes
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      mco_q <= mcc_pkg::CSR_RST[mcc_pkg::MCO_BIT];
      cp_q <= mcc_pkg::CSR_RST[mcc_pkg::CP_LSB +: 2];
      sms_q <= mcc_pkg::CSR_RST[mcc_pkg::SMS_BIT];
      tb_sel_q <= mcc_pkg::CSR_RST[mcc_pkg::TB_LSB +: 2];
      oie_q <= mcc_pkg::CSR_RST[mcc_pkg::OIE_BIT];
    end else if (ce_i && we_csr) begin
      mco_q <= hwdata_i[mcc_pkg::MCO_BIT];
      cp_q <= hwdata_i[mcc_pkg::CP_LSB +: 2];
      sms_q <= hwdata_i[mcc_pkg::SMS_BIT];
      tb_sel_q <= hwdata_i[mcc_pkg::TB_LSB +: 2];
      oie_q <= hwdata_i[mcc_pkg::OIE_BIT];
    end
  end

  // Only the tone field is stored; upper bits read as zero
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      tone_q <= mcc_pkg::BCR_RST[mcc_pkg::TONE_LSB +: 2];
    end else if (ce_i && we_bcr) begin
      tone_q <= hwdata_i[mcc_pkg::TONE_LSB +: 2];
    end
  end

  // Flag: a period end in the same cycle as the read wins
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      oif_q <= mcc_pkg::CSR_RST[mcc_pkg::OIF_BIT];
    end else if (ce_i) begin
      if (tb_tick) begin
        oif_q <= 1'b1;
      end else if (rd_csr && !frozen) begin
        oif_q <= 1'b0;
      end
    end
  end

  // ---- Power state
  always_comb begin
    ps_d = ps_q;
    unique case (ps_q)
      mcc_pkg::PS_RUN: begin
        if (halt_exec_i) begin
          ps_d = oie_q ? mcc_pkg::PS_AHALT : mcc_pkg::PS_HALT;
        end
      end
      mcc_pkg::PS_AHALT: begin
        if ((oif_q && oie_q) || wake_i) begin
          ps_d = mcc_pkg::PS_RUN;
        end
      end
      mcc_pkg::PS_HALT: begin
        if (wake_i) begin
          ps_d = mcc_pkg::PS_RUN;
        end
      end
      default: ps_d = mcc_pkg::PS_RUN;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ps_q <= mcc_pkg::PS_RUN;
      ahalt_q <= 1'b0;
      halt_q <= 1'b0;
    end else if (ce_i) begin
      ps_q <= ps_d;
      ahalt_q <= (ps_d == mcc_pkg::PS_AHALT);
      halt_q <= (ps_d == mcc_pkg::PS_HALT);
    end
  end

  // Interrupt request; wait mode does not gate it
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      irq_q <= 1'b0;
    end else if (ce_i) begin
      irq_q <= oif_q && oie_q && !irq_mask_i;
    end
  end

  // ---- Time base, free running except in full halt
  assign tb_run = (ps_q != mcc_pkg::PS_HALT);
  assign tb_period = tb_cycles(tb_sel_q);

  tick_div #(
    .W(mcc_pkg::TB_W),
    .INIT(mcc_pkg::TB_W'(TB_CYC_0))
  ) u_time_base (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i && tb_run),
    .run_i(1'b1),
    .period_i(tb_period),
    .tick_o(tb_tick_raw)
  );
  // Counter holds its count in full halt; a count parked at the end must not tick
  assign tb_tick = tb_tick_raw && tb_run;

  // ---- Beeper, kept running in active-halt
  always_comb begin
    unique case (tone_q)
      2'b01: beep_period = mcc_pkg::BEEP_W'(BEEP_HALF_1);
      2'b10: beep_period = mcc_pkg::BEEP_W'(BEEP_HALF_2);
      2'b11: beep_period = mcc_pkg::BEEP_W'(BEEP_HALF_3);
      2'b00: beep_period = mcc_pkg::BEEP_W'(BEEP_HALF_1);
    endcase
  end
  assign beep_run = (tone_q != 2'b00) && (ps_q != mcc_pkg::PS_HALT);

  tick_div #(
    .W(mcc_pkg::BEEP_W),
    .INIT(mcc_pkg::BEEP_W'(BEEP_HALF_1))
  ) u_beep (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .run_i(beep_run),
    .period_i(beep_period),
    .tick_o(beep_tick)
  );

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      beep_q <= 1'b0;
      beep_oe_q <= 1'b0;
    end else if (ce_i) begin
      beep_oe_q <= (tone_q != 2'b00);
      if (!beep_run) begin
        beep_q <= 1'b0;
      end else if (beep_tick) begin
        beep_q <= !beep_q;
      end
    end
  end

  // ---- CPU clock prescaler
  assign cpu_run = sms_q && (ps_q == mcc_pkg::PS_RUN);
  assign cpu_period = mcc_pkg::CPU_DIV_MIN << cp_q;

  tick_div #(
    .W(mcc_pkg::CPU_W),
    .INIT(mcc_pkg::CPU_DIV_MIN)
  ) u_cpu_div (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .run_i(cpu_run),
    .period_i(cpu_period),
    .tick_o(cpu_tick)
  );

  assign cpu_en_d = (ps_q == mcc_pkg::PS_RUN) && (!sms_q || cpu_tick);

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cpu_en_q <= 1'b0;
    end else if (ce_i) begin
      cpu_en_q <= cpu_en_d;
    end
  end

  // ---- Clock-out: toggles on each CPU clock enable, low outside run
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      clk_out_q <= 1'b0;
      clk_out_oe_q <= 1'b0;
    end else if (ce_i) begin
      clk_out_oe_q <= mco_q;
      if (!mco_q || ps_q != mcc_pkg::PS_RUN) begin
        clk_out_q <= 1'b0;
      end else if (cpu_en_d) begin
        clk_out_q <= !clk_out_q;
      end
    end
  end

  assign hrdata_o = hrdata_q;
  assign hreadyout_o = hready_q;
  assign hresp_o = mcc_pkg::HRESP_OKAY;
  assign cpu_clk_en_o = cpu_en_q;
  assign clock_out_o = clk_out_q;
  assign clock_out_oe_o = clk_out_oe_q;
  assign beep_o = beep_q;
  assign beep_oe_o = beep_oe_q;
  assign time_base_irq_o = irq_q;
  assign active_halt_o = ahalt_q;
  assign halt_o = halt_q;

  // ---- Assertions
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  logic slow2;
  assign slow2 = ce_i && sms_q && (cp_q == 2'b00) && (ps_q == mcc_pkg::PS_RUN) && !we_csr;

  sequence s_slow2_tick;
    slow2 && cpu_tick;
  endsequence

  sequence s_slow2_two;
    slow2 ##1 slow2;
  endsequence

  a_flag_set: assert property (
    (ce_i && tb_tick) |=> oif_q)
    else $error("flag not set at period end");

  a_flag_read_clear: assert property (
    (ce_i && rd_csr && !frozen && !tb_tick) |=> !oif_q)
    else $error("flag not cleared by read");

  a_flag_write_keep: assert property (
    (ce_i && we_csr && oif_q && !rd_csr) |=> oif_q)
    else $error("flag cleared by a write");

  a_irq_gate: assert property (
    (ce_i && oif_q && oie_q && !irq_mask_i) |=> time_base_irq_o)
    else $error("interrupt not raised");

  a_irq_off: assert property (
    (ce_i && (!oie_q || irq_mask_i)) |=> !time_base_irq_o)
    else $error("interrupt raised while disabled");

  a_ahalt_entry: assert property (
    (ce_i && ps_q == mcc_pkg::PS_RUN && halt_exec_i && oie_q) |=> active_halt_o && !halt_o)
    else $error("active-halt not entered");

  a_halt_frozen: assert property (
    (ps_q == mcc_pkg::PS_HALT) |-> !tb_tick && !beep_tick)
    else $error("counting in full halt");

  a_halt_no_irq_wake: assert property (
    (ce_i && ps_q == mcc_pkg::PS_HALT && !wake_i) |=> halt_o)
    else $error("left halt without wake source");

  a_clkout_suspend: assert property (
    (ce_i && ps_q == mcc_pkg::PS_AHALT) |=> !clock_out_o)
    else $error("clock-out active in active-halt");

  a_normal_speed: assert property (
    (ce_i && ps_q == mcc_pkg::PS_RUN && !sms_q) |=> cpu_clk_en_o)
    else $error("CPU clock enable missing in normal mode");

  a_slow_div2: assert property (
    s_slow2_tick ##1 s_slow2_two |-> cpu_tick && !$past(cpu_tick))
    else $error("slow divide by two wrong");

  a_beep_off: assert property (
    (ce_i && tone_q == 2'b00) |=> !beep_o)
    else $error("beep active while off");

endmodule : main_clock_rtc_beeper

/* src/mcc_pkg.sv */
// Constants and types shared by the clock controller and its testbench
package mcc_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [7:0] CSR_IDX = 8'h2C;
  localparam logic [7:0] BCR_IDX = 8'h2D;
  localparam logic [31:0] CSR_ADDR = {22'h000000, CSR_IDX, 2'b00};
  localparam logic [31:0] BCR_ADDR = {22'h000000, BCR_IDX, 2'b00};
  localparam logic [7:0] CSR_RST = 8'h00;
  localparam logic [7:0] BCR_RST = 8'h00;
  // Field positions of clock_ctrl_status
  localparam int MCO_BIT = 7;
  localparam int CP_LSB = 5;
  localparam int SMS_BIT = 4;
  localparam int TB_LSB = 2;
  localparam int OIE_BIT = 1;
  localparam int OIF_BIT = 0;
  // Field position of beep_control
  localparam int TONE_LSB = 0;
  // Time base periods in oscillator cycles
  localparam int TB_W = 18;
  localparam int TB_CYC_0 = 16000;
  localparam int TB_CYC_1 = 32000;
  localparam int TB_CYC_2 = 80000;
  localparam int TB_CYC_3 = 200000;
  // Tone half periods derived from the reference oscillator rate
  localparam int BEEP_W = 13;
  localparam int BEEP_REF_HZ = 8000000;
  localparam int TONE_HZ_1 = 2000;
  localparam int TONE_HZ_2 = 1000;
  localparam int TONE_HZ_3 = 500;
  localparam int BEEP_HALF_1 = BEEP_REF_HZ / (2 * TONE_HZ_1);
  localparam int BEEP_HALF_2 = BEEP_REF_HZ / (2 * TONE_HZ_2);
  localparam int BEEP_HALF_3 = BEEP_REF_HZ / (2 * TONE_HZ_3);
  // Slow-mode divider: smallest ratio, shifted by the prescaler code
  localparam int CPU_W = 5;
  localparam logic [4:0] CPU_DIV_MIN = 5'h02;
  // Bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic HRESP_OKAY = 1'b0;
  typedef enum logic [2:0] {
    PS_RUN = 3'b001,
    PS_AHALT = 3'b010,
    PS_HALT = 3'b100
  } power_state_e;
endpackage : mcc_pkg

/* src/tick_div.sv */
// Free-running period divider that adopts a new period only at wrap or while run_i is low
`timescale 1ns/10ps
module tick_div #(
  parameter int W = 8,
  parameter logic [W-1:0] INIT = 2
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic run_i,
  input wire logic [W-1:0] period_i,
  output logic tick_o
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] per_q;

  if (W < 2) begin : g_bad_width
    $error("tick_div: W must be at least 2");
  end

  assign tick_o = run_i && (cnt_q == per_q - 1'b1);

  // Period change waits for the end of the period in progress
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
      per_q <= INIT;
    end else if (ce_i) begin
      if (!run_i || tick_o) begin
        cnt_q <= '0;
        per_q <= period_i;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
endmodule : tick_div

/* dv/clk_consumer.sv */
// Model of the CPU core and an outside part fed by the generated clocks
`timescale 1ns/10ps
module clk_consumer (
  input wire logic ref_clk_i,
  input wire logic clr_i,
  input wire logic cpu_en_i,
  input wire logic pin_i,
  output int cpu_cnt_o,
  output int pin_cnt_o
);
  logic pin_q;
  always_ff @(posedge ref_clk_i) begin
    pin_q <= pin_i;
    if (clr_i) begin
      cpu_cnt_o <= 0;
      pin_cnt_o <= 0;
    end else begin
      // The core advances only on cycles the controller enables
      if (cpu_en_i === 1'b1) cpu_cnt_o <= cpu_cnt_o + 1;
      // The outside part counts rising edges of the clock-out pin
      if (pin_i === 1'b1 && pin_q === 1'b0) pin_cnt_o <= pin_cnt_o + 1;
    end
  end
endmodule : clk_consumer

/* dv/tb_top.sv */
// Self-checking bench for the clock controller
`timescale 1ns/10ps
module tb_top;
  localparam logic [31:0] CSR = mcc_pkg::CSR_ADDR;
  localparam logic [31:0] BCR = mcc_pkg::BCR_ADDR;
  typedef struct {logic [31:0] a; logic [7:0] d; logic [7:0] m; logic [7:0] e;} row_s;
  localparam int TB_C0 = 20, TB_C1 = 30, TB_C2 = 40, TB_C3 = 50;
  localparam int BH_1 = 4, BH_2 = 6, BH_3 = 8;
  logic ref_clk_i, rst_n_i, hsel, hwrite, irq_mask, halt_exec, wake, clr, ce;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic hready, hresp, cpu_en, clk_out, clk_oe, beep, beep_oe, irq, ahalt, halt;
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int cnt, ext, ticks, edges, t0, t1, hi;
  int tbc[4] = '{TB_C0, TB_C1, TB_C2, TB_C3};
  int bh[4] = '{0, BH_1, BH_2, BH_3};
  row_s rows[5] = '{'{CSR, 8'hFE, 8'hFE, 8'hFE}, '{BCR, 8'h03, 8'hFF, 8'h03},
    '{BCR, 8'h02, 8'hFF, 8'h02}, '{CSR, 8'h00, 8'hFE, 8'h00}, '{32'hB8, 8'hFF, 8'hFF, 8'h00}};

  main_clock_rtc_beeper #(.TB_CYC_0(TB_C0), .TB_CYC_1(TB_C1), .TB_CYC_2(TB_C2), .TB_CYC_3(TB_C3),
    .BEEP_HALF_1(BH_1), .BEEP_HALF_2(BH_2), .BEEP_HALF_3(BH_3)) DUT (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce),
    .hsel_i(hsel),
    .haddr_i(haddr),
    .htrans_i(htrans),
    .hwrite_i(hwrite),
    .hsize_i(hsize),
    .hready_i(hready),
    .hwdata_i(hwdata),
    .hrdata_o(hrdata),
    .hreadyout_o(hready),
    .hresp_o(hresp),
    .irq_mask_i(irq_mask),
    .halt_exec_i(halt_exec),
    .wake_i(wake),
    .cpu_clk_en_o(cpu_en),
    .clock_out_o(clk_out),
    .clock_out_oe_o(clk_oe),
    .beep_o(beep),
    .beep_oe_o(beep_oe),
    .time_base_irq_o(irq),
    .active_halt_o(ahalt),
    .halt_o(halt)
  );

  clk_consumer u_cons (
    .ref_clk_i(ref_clk_i),
    .clr_i(clr),
    .cpu_en_i(cpu_en),
    .pin_i(clk_out),
    .cpu_cnt_o(cnt),
    .pin_cnt_o(ext)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic summarize();
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      summarize();
    end
  end

  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t value %h expected %h", $time, g, e);
    end
  endtask : chk_val

  task automatic chk_cnt(input int g, input int e);
    n_compared++;
    if (g != e) begin
      errors++;
      $display("[ERR] %0t count %0d expected %0d", $time, g, e);
    end
  endtask : chk_cnt

  // One single AHB transfer; read data lands in rd
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= mcc_pkg::HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'b010;
    do @(posedge ref_clk_i); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge ref_clk_i); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb

  function automatic logic sig(input int s);
    logic [3:0] v;
    v = {beep, halt, ahalt, irq};
    return v[s];
  endfunction : sig

  task automatic wait_for(input int s, input logic v);
    int k;
    k = 0;
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (sig(s) !== v && k < 300);
    if (k >= 300) chk_cnt(k, 0);
  endtask : wait_for

  // Counts CPU enables and clock-out edges over n cycles
  task automatic measure(input int n);
    clr <= 1'b1;
    @(posedge ref_clk_i);
    clr <= 1'b0;
    repeat (n) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    ticks = cnt;
    edges = ext;
    @(posedge ref_clk_i);
  endtask : measure

  // Width of one full high phase of the tone
  task automatic half();
    wait_for(3, 1'b0);
    wait_for(3, 1'b1);
    hi = 0;
    while (beep === 1'b1 && hi < 300) begin
      @(posedge ref_clk_i);
      hi++;
    end
  endtask : half

  initial begin
    rst_n_i = 1'b0;
    {hsel, hwrite, irq_mask, halt_exec, wake, clr} = '0;
    htrans = 2'b00;
    hsize = 3'b010;
    ce = 1'b1;
    haddr = '0;
    hwdata = '0;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    ahb(1'b0, CSR, 0);
    chk_val(rd, 32'h0);
    ahb(1'b0, BCR, 0);
    chk_val(rd, 32'h0);
    chk_val(hresp, mcc_pkg::HRESP_OKAY);
    for (int i = 0; i < 5; i++) begin
      ahb(1'b1, rows[i].a, {24'h0, rows[i].d});
      ahb(1'b0, rows[i].a, 0);
      chk_val(rd & {24'h0, rows[i].m}, {24'h0, rows[i].e});
    end
    for (int m = 0; m < 5; m++) begin
      ahb(1'b1, CSR, (m == 0) ? 32'h80 : (32'h90 | ((m - 1) << 5)));
      repeat (32) @(posedge ref_clk_i);
      measure(64);
      chk_cnt(ticks, 64 >> m);
      chk_cnt(edges, 32 >> m);
      chk_val(clk_oe, 1'b1);
    end
    for (int k = 1; k < 4; k++) begin
      ahb(1'b1, BCR, k);
      half();
      half();
      chk_cnt(hi, bh[k]);
      chk_val(beep_oe, 1'b1);
    end
    ahb(1'b1, BCR, 0);
    ahb(1'b1, CSR, 0);
    measure(40);
    chk_cnt(ticks, 40);
    chk_val({edges[0], clk_oe, beep, beep_oe}, 4'h0);
    ahb(1'b1, CSR, 32'h02);
    wait_for(0, 1'b1);
    ahb(1'b0, CSR, 0);
    wait_for(0, 1'b1);
    t0 = cyc;
    ahb(1'b0, CSR, 0);
    for (int k = 1; k < 4; k++) begin
      ahb(1'b1, CSR, 32'h02 | (k << 2));
      wait_for(0, 1'b1);
      t1 = cyc;
      chk_cnt(t1 - t0, tbc[k - 1]);
      ahb(1'b0, CSR, 0);
      wait_for(0, 1'b1);
      t0 = cyc;
      chk_cnt(t0 - t1, tbc[k]);
      ahb(1'b0, CSR, 0);
    end
    irq_mask <= 1'b1;
    ahb(1'b1, CSR, 32'h02);
    repeat (70) @(posedge ref_clk_i);
    chk_val(irq, 1'b0);
    ahb(1'b0, CSR, 0);
    chk_val(rd[0], 1'b1);
    ahb(1'b0, CSR, 0);
    chk_val(rd[0], 1'b0);
    irq_mask <= 1'b0;
    ahb(1'b1, BCR, 1);
    ahb(1'b1, CSR, 32'h86);
    wait_for(0, 1'b1);
    ahb(1'b0, CSR, 0);
    wait_for(0, 1'b1);
    t0 = cyc;
    ahb(1'b0, CSR, 0);
    halt_exec <= 1'b1;
    @(posedge ref_clk_i);
    halt_exec <= 1'b0;
    @(posedge ref_clk_i);
    chk_val({ahalt, halt}, 2'b10);
    ahb(1'b1, BCR, 0);
    measure(4);
    chk_cnt(ticks + edges, 0);
    half();
    chk_cnt(hi, bh[1]);
    wait_for(1, 1'b0);
    chk_cnt(int'(cyc - t0 <= 32), 1);
    ahb(1'b0, BCR, 0);
    chk_val(rd, 32'h1);
    ahb(1'b0, CSR, 0);
    ahb(1'b1, CSR, 32'h02);
    wait_for(0, 1'b1);
    ahb(1'b1, CSR, 0);
    ahb(1'b0, CSR, 0);
    halt_exec <= 1'b1;
    @(posedge ref_clk_i);
    halt_exec <= 1'b0;
    @(posedge ref_clk_i);
    chk_val({ahalt, halt}, 2'b01);
    repeat (200) @(posedge ref_clk_i);
    chk_val({halt, cpu_en}, 2'b10);
    wake <= 1'b1;
    @(posedge ref_clk_i);
    wake <= 1'b0;
    wait_for(2, 1'b0);
    ahb(1'b0, CSR, 0);
    chk_val(rd[0], 1'b0);
    repeat (40) @(posedge ref_clk_i);
    ahb(1'b0, CSR, 0);
    chk_val(rd[0], 1'b1);
    // Clock enable low holds the time base; a period would otherwise end meanwhile
    ce <= 1'b0;
    repeat (60) @(posedge ref_clk_i);
    ce <= 1'b1;
    ahb(1'b0, CSR, 0);
    chk_val(rd[0], 1'b0);
    summarize();
  end
endmodule : tb_top
